// ---- hdl/csfc_map.svh ----
// Register offsets, field values, reset values and timing figures.
`ifndef CSFC_MAP_SVH
`define CSFC_MAP_SVH
// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define CSFC_ADDR_FAULT   8'h00
`define CSFC_ADDR_VOUT    8'h02
`define CSFC_ADDR_ICHG    8'h04
`define CSFC_ADDR_HOLD    8'h05
`define CSFC_ADDR_CEIL    8'h06
// ---------------------------------------------------------------------
// Field values
// ---------------------------------------------------------------------
`define CSFC_FLT_NONE     3'h0
`define CSFC_FLT_OVP      3'h1
`define CSFC_FLT_SLEEP    3'h2
`define CSFC_FLT_POOR     3'h3
`define CSFC_FLT_THERM    3'h5
`define CSFC_STAT_READY   2'h0
`define CSFC_STAT_CHG     2'h1
`define CSFC_STAT_FAULT   2'h3
`define CSFC_VOUT_BASE    6'h23
`define CSFC_FOLD_CODE    3'h0
// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define CSFC_VOUT_RST     6'h00
`define CSFC_ICHG_RST     3'h0
`define CSFC_HOLD_RST     3'h0
`define CSFC_CEIL_RST     7'h00
// ---------------------------------------------------------------------
// Timing, clock in kHz, times in their own units
// ---------------------------------------------------------------------
`define CSFC_CLK_KHZ      25000
`define CSFC_VALID_MS     30
`define CSFC_RETRY_MS     2000
`define CSFC_PULSE_US     128
`define CSFC_RAMP_US      100
`define CSFC_PULSE_CYC    (`CSFC_PULSE_US * `CSFC_CLK_KHZ / 1000)
`define CSFC_RAMP_CYC     (`CSFC_RAMP_US * `CSFC_CLK_KHZ / 1000)
`endif

// ---- hdl/csfc_pkg.sv ----
// Types shared by the charger safety and fault control block.
package csfc_pkg;

  typedef enum logic [1:0] {
    CSFC_ST_VALID  = 2'b00,
    CSFC_ST_CHARGE = 2'b01,
    CSFC_ST_OVP    = 2'b10,
    CSFC_ST_RETRY  = 2'b11
  } csfc_fsm_t;

  // Comparator and sensor levels, all synchronous to the clock.
  typedef struct packed {
    logic vbus_min;     // Input above minimum input threshold.
    logic input_overvoltage_threshold;     // Input above overvoltage threshold.
    logic input_overvoltage_threshold_clr; // Input 150 mV or more below that threshold.
    logic vbus_sleep;   // Input below battery plus sleep margin.
    logic vbus_hold;    // Input sagged to the hold threshold.
    logic at_limit;     // Input current limit or charge current reached.
    logic vbat_ok;      // Battery above the short-circuit threshold.
    logic die_fold;     // Die at foldback temperature.
    logic die_shut;     // Die above shutdown temperature.
  } csfc_sense_t;

  // One decoded register-port access.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csfc_reg_req_t;

  typedef struct packed {
    csfc_fsm_t   fsm;
    logic [25:0] cnt;
    logic [11:0] pulse_cnt;
    logic [11:0] ramp_cnt;
    logic [2:0]  ramp;
    logic [2:0]  fault;
    logic [1:0]  stat;
    logic [5:0]  vout;
    logic [2:0]  ichg;
    logic [2:0]  hold;
    logic        hold_act;
    logic [6:0]  ceil;
    logic        lock;
    logic        vbat_ok;
    logic        therm;
    logic        charge_en;
    logic        blk_on;
    logic        sleep;
    logic        stat_pin;
    logic        fold;
    logic [2:0]  i_eff;
    logic [7:0]  rdata;
  } csfc_state_t;

endpackage

// ---- hdl/csfc_top.sv ----
// Charger safety ceiling, input hold, thermal and input-fault control.
`timescale 1ns/100ps
`include "csfc_map.svh"

module csfc_top #(
  parameter int VALID_CYC = `CSFC_VALID_MS * `CSFC_CLK_KHZ,
  parameter int RETRY_CYC = `CSFC_RETRY_MS * `CSFC_CLK_KHZ
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // Analog sense levels
  input  wire csfc_pkg::csfc_sense_t  sense,
  // Register port
  input  wire csfc_pkg::csfc_reg_req_t reg_req,
  output logic [7:0]                  reg_rdata,
  // Power path control
  output logic                        charge_enable,
  output logic                        blocking_switch_on,
  output logic                        sleep_active,
  output logic                        stat_pulse,
  output logic                        foldback_active,
  output logic [2:0]                  charge_current_level,
  output logic [5:0]                  output_voltage_code,
  output logic [2:0]                  input_hold_threshold,
  output logic                        hold_active
);
  import csfc_pkg::*;

  localparam int PULSE_CYC = `CSFC_PULSE_CYC;
  localparam int RAMP_CYC  = `CSFC_RAMP_CYC;

  csfc_state_t state_q;
  csfc_state_t state_d;

  // -------------------------------------------------------------------
  // Ceiling helpers
  // -------------------------------------------------------------------
  // Unsigned compare against the limit; the limit wins on overflow.
  function automatic logic [5:0] clamp_v(logic [5:0] code,
                                         logic [6:0] ceil);
    logic [5:0] lim;
    lim = `CSFC_VOUT_BASE + {2'h0, ceil[3:0]};
    return (code > lim) ? lim : code;
  endfunction

  function automatic logic [2:0] clamp_i(logic [2:0] code,
                                         logic [6:0] ceil);
    return (code > ceil[6:4]) ? ceil[6:4] : code;
  endfunction

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  // Each fault entry except sleep restarts the status pulse; a fault seen while a
  // pulse is running simply stretches it, which the host tolerates.
  always_comb begin
    state_d = state_q;
    if (state_q.pulse_cnt != 12'h000) begin
      state_d.pulse_cnt = state_q.pulse_cnt - 12'h001;
    end

    // Ceiling register load and lock follow the battery level.
    state_d.vbat_ok = sense.vbat_ok;
    if (!sense.vbat_ok) begin
      state_d.lock = 1'b1;
    end else if (!state_q.vbat_ok) begin
      state_d.ceil = `CSFC_CEIL_RST;
      state_d.lock = 1'b0;
    end

    // Register writes.
    if (reg_req.wr) begin
      if (reg_req.addr == `CSFC_ADDR_CEIL) begin
        if (!state_d.lock) begin
          state_d.ceil = reg_req.wdata[6:0];
          state_d.vout = clamp_v(state_q.vout, reg_req.wdata[6:0]);
          state_d.ichg = clamp_i(state_q.ichg, reg_req.wdata[6:0]);
        end
      end else begin
        state_d.lock = 1'b1;
      end
      if (reg_req.addr == `CSFC_ADDR_VOUT) begin
        state_d.vout = clamp_v(reg_req.wdata[7:2], state_q.ceil);
      end
      if (reg_req.addr == `CSFC_ADDR_ICHG) begin
        state_d.ichg = clamp_i(reg_req.wdata[6:4], state_q.ceil);
      end
      if (reg_req.addr == `CSFC_ADDR_HOLD) begin
        state_d.hold = reg_req.wdata[2:0];
      end
    end
    // Stored codes follow the ceiling that will stand, so reloading the
    // default after a battery short also pulls them under the limit.
    state_d.vout = clamp_v(state_d.vout, state_d.ceil);
    state_d.ichg = clamp_i(state_d.ichg, state_d.ceil);

    // Register reads return the state seen in the read cycle.
    if (reg_req.rd) begin
      case (reg_req.addr)
        `CSFC_ADDR_FAULT: state_d.rdata = {2'h0, state_q.stat, 1'b0,
                                           state_q.fault};
        `CSFC_ADDR_VOUT:  state_d.rdata = {state_q.vout, 2'h0};
        `CSFC_ADDR_ICHG:  state_d.rdata = {1'b0, state_q.ichg, 4'h0};
        `CSFC_ADDR_HOLD:  state_d.rdata = {3'h0, state_q.hold_act, 1'b0,
                                           state_q.hold};
        `CSFC_ADDR_CEIL:  state_d.rdata = {1'b0, state_q.ceil};
        default:          state_d.rdata = 8'h00;
      endcase
    end

    state_d.fold  = sense.die_fold;
    state_d.therm = sense.die_shut;
    if (sense.die_shut) begin
      // Sequence and timers freeze, all but the status pulse, so charging resumes where it stopped.
      state_d.charge_en = 1'b0;
      state_d.hold_act  = 1'b0;
      if (!state_q.therm) begin
        state_d.fault     = `CSFC_FLT_THERM;
        state_d.stat      = `CSFC_STAT_FAULT;
        state_d.pulse_cnt = 12'(PULSE_CYC);
      end
    end else begin
      if (state_q.therm) begin
        state_d.fault = `CSFC_FLT_NONE;
        state_d.stat  = (state_q.fsm == CSFC_ST_CHARGE) ?
                        `CSFC_STAT_CHG : `CSFC_STAT_READY;
      end
      state_d.sleep    = 1'b0;
      state_d.hold_act = 1'b0;
      case (state_q.fsm)
        CSFC_ST_VALID: begin
          state_d.charge_en = 1'b0;
          state_d.blk_on    = 1'b1;
          state_d.ramp      = 3'h0;
          state_d.cnt       = 26'h0;
          if (sense.input_overvoltage_threshold) begin
            state_d.fsm       = CSFC_ST_OVP;
            state_d.blk_on    = 1'b0;
            state_d.fault     = `CSFC_FLT_OVP;
            state_d.stat      = `CSFC_STAT_FAULT;
            state_d.pulse_cnt = 12'(PULSE_CYC);
          end else if (sense.vbus_min && sense.vbus_sleep) begin
            state_d.sleep = 1'b1;
            state_d.fault = `CSFC_FLT_SLEEP;
          end else if (sense.vbus_min) begin
            if (state_q.cnt == 26'(VALID_CYC - 1)) begin
              state_d.fsm   = CSFC_ST_CHARGE;
              state_d.fault = `CSFC_FLT_NONE;
              state_d.stat  = `CSFC_STAT_CHG;
            end else begin
              state_d.cnt = state_q.cnt + 26'h1;
            end
          end
        end
        CSFC_ST_CHARGE: begin
          state_d.charge_en = 1'b1;
          state_d.blk_on    = 1'b1;
          state_d.hold_act  = sense.vbus_hold;
          if (sense.input_overvoltage_threshold) begin
            state_d.fsm       = CSFC_ST_OVP;
            state_d.charge_en = 1'b0;
            state_d.blk_on    = 1'b0;
            state_d.fault     = `CSFC_FLT_OVP;
            state_d.stat      = `CSFC_STAT_FAULT;
            state_d.pulse_cnt = 12'(PULSE_CYC);
          end else if (!sense.vbus_min) begin
            state_d.fsm       = CSFC_ST_RETRY;
            state_d.cnt       = 26'h0;
            state_d.charge_en = 1'b0;
            state_d.fault     = `CSFC_FLT_POOR;
            state_d.stat      = `CSFC_STAT_FAULT;
            state_d.pulse_cnt = 12'(PULSE_CYC);
          end else if (sense.vbus_sleep) begin
            state_d.fsm       = CSFC_ST_VALID;
            state_d.charge_en = 1'b0;
            state_d.sleep     = 1'b1;
            state_d.stat      = `CSFC_STAT_READY;
          end else if (state_q.ramp > state_q.ichg) begin
            state_d.ramp = state_q.ichg;
          end else if (state_q.ramp_cnt == 12'(RAMP_CYC - 1)) begin
            state_d.ramp_cnt = 12'h000;
            if (!sense.at_limit && !sense.vbus_hold &&
                state_q.ramp < state_q.ichg) begin
              state_d.ramp = state_q.ramp + 3'h1;
            end
          end else begin
            state_d.ramp_cnt = state_q.ramp_cnt + 12'h001;
          end
        end
        CSFC_ST_OVP: begin
          state_d.charge_en = 1'b0;
          state_d.blk_on    = 1'b0;
          if (sense.input_overvoltage_threshold_clr) begin
            state_d.fsm   = CSFC_ST_VALID;
            state_d.fault = `CSFC_FLT_NONE;
            state_d.stat  = `CSFC_STAT_READY;
            state_d.cnt   = 26'h0;
          end
        end
        CSFC_ST_RETRY: begin
          state_d.charge_en = 1'b0;
          if (state_q.cnt != 26'(RETRY_CYC - 1)) begin
            state_d.cnt = state_q.cnt + 26'h1;
          end else if (sense.vbus_min) begin
            state_d.fsm = CSFC_ST_VALID;
            state_d.cnt = 26'h0;
          end
        end
        default: begin
          state_d.fsm = CSFC_ST_VALID;
        end
      endcase
    end
    state_d.stat_pin = (state_d.pulse_cnt != 12'h000);
    // The lowest current code is the foldback current.
    state_d.i_eff = sense.die_fold ? `CSFC_FOLD_CODE : state_d.ramp;
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q      <= '0;
      state_q.vout <= `CSFC_VOUT_RST;
      state_q.ichg <= `CSFC_ICHG_RST;
      state_q.hold <= `CSFC_HOLD_RST;
      state_q.ceil <= `CSFC_CEIL_RST;
      state_q.lock <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata            = state_q.rdata;
  assign charge_enable        = state_q.charge_en;
  assign blocking_switch_on   = state_q.blk_on;
  assign sleep_active         = state_q.sleep;
  assign stat_pulse           = state_q.stat_pin;
  assign foldback_active      = state_q.fold;
  assign charge_current_level = state_q.i_eff;
  assign output_voltage_code  = state_q.vout;
  assign input_hold_threshold = state_q.hold;
  assign hold_active          = state_q.hold_act;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence valid_run_s;
    state_q.fsm == CSFC_ST_VALID ##1 state_q.fsm == CSFC_ST_CHARGE;
  endsequence

  vout_ceiling_a: assert property (
    state_q.vout <= `CSFC_VOUT_BASE + {2'h0, state_q.ceil[3:0]})
    else $error("Voltage code above its ceiling.");
  ichg_ceiling_a: assert property (
    state_q.ichg <= state_q.ceil[6:4])
    else $error("Current code above its ceiling.");
  clamp_write_a: assert property (
    reg_req.wr && reg_req.addr == `CSFC_ADDR_ICHG &&
    reg_req.wdata[6:4] > state_q.ceil[6:4] && state_q.lock
    |=> state_q.ichg == state_q.ceil[6:4])
    else $error("Overlarge current write not clamped.");
  lock_set_a: assert property (
    reg_req.wr && reg_req.addr != `CSFC_ADDR_CEIL && sense.vbat_ok
    |=> state_q.lock ##1 (state_q.lock || !$past(sense.vbat_ok) ||
        !$past(state_q.vbat_ok)))
    else $error("Ceiling not locked after other write.");
  locked_hold_a: assert property (
    state_q.lock && state_q.vbat_ok && sense.vbat_ok
    |=> $stable(state_q.ceil))
    else $error("Locked ceiling register changed.");
  load_default_a: assert property (
    sense.vbat_ok && !state_q.vbat_ok && !reg_req.wr
    |=> state_q.ceil == `CSFC_CEIL_RST && !state_q.lock)
    else $error("Ceiling default not loaded.");
  therm_fault_a: assert property (
    sense.die_shut && !state_q.therm
    |=> state_q.fault == `CSFC_FLT_THERM && state_q.stat_pin &&
        !state_q.charge_en)
    else $error("Thermal shutdown not reported.");
  therm_freeze_a: assert property (
    sense.die_shut |=> $stable(state_q.fsm) && $stable(state_q.cnt))
    else $error("Sequence moved during thermal suspend.");
  fold_curr_a: assert property (
    sense.die_fold |=> charge_current_level == `CSFC_FOLD_CODE)
    else $error("Foldback current not applied.");
  ovp_entry_a: assert property (
    state_q.fsm == CSFC_ST_CHARGE && sense.input_overvoltage_threshold && !sense.die_shut
    |=> (!blocking_switch_on && state_q.fault == `CSFC_FLT_OVP &&
        state_q.stat == `CSFC_STAT_FAULT) ##0 stat_pulse [*8])
    else $error("Overvoltage entry wrong.");
  uv_entry_a: assert property (
    state_q.fsm == CSFC_ST_CHARGE && !sense.input_overvoltage_threshold &&
    !sense.vbus_min && !sense.die_shut
    |=> state_q.fsm == CSFC_ST_RETRY && !charge_enable &&
        state_q.fault == `CSFC_FLT_POOR && stat_pulse)
    else $error("Undervoltage entry wrong.");
  ovp_clear_a: assert property (
    state_q.fsm == CSFC_ST_OVP && sense.input_overvoltage_threshold_clr && !sense.die_shut
    |=> state_q.fsm == CSFC_ST_VALID && state_q.fault == `CSFC_FLT_NONE)
    else $error("Overvoltage fault not cleared.");
  valid_time_a: assert property (
    valid_run_s |-> $past(state_q.cnt) == 26'(VALID_CYC - 1))
    else $error("Charging began before validation time.");
  ramp_step_a: assert property (
    state_q.fsm == CSFC_ST_CHARGE && state_q.ramp > $past(state_q.ramp)
    |-> !$past(sense.at_limit) && !$past(sense.vbus_hold))
    else $error("Ramp stepped while limited.");

endmodule // csfc_top

// ---- tb/csfc_host.sv ----
// Host processor model for the register port of the charger block.
`timescale 1ns/100ps
`include "csfc_map.svh"
module csfc_host (
  // Clock
  input  wire logic                    clk_sys,
  // Register port
  output csfc_pkg::csfc_reg_req_t      reg_req,
  input  wire logic [7:0]              reg_rdata
);
  import csfc_pkg::*;

  // The port idles with no request pending.
  initial reg_req = '0;

  // One write, held until the taking edge; released lines are inverted.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req.wr    <= 1'b1;
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    @(posedge clk_sys);
    reg_req.wr    <= 1'b0;
    reg_req.addr  <= ~a;
    reg_req.wdata <= ~d;
  endtask

  // The whole ceiling value goes twice; each write alone lands every bit.
  task automatic wr_ceil(input logic [7:0] d);
    wr(`CSFC_ADDR_CEIL, d);
    wr(`CSFC_ADDR_CEIL, d);
  endtask

  // One read; data is taken once the registered answer has settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_req.rd   <= 1'b1;
    reg_req.addr <= a;
    @(posedge clk_sys);
    reg_req.rd   <= 1'b0;
    reg_req.addr <= ~a;
    @(posedge clk_sys);
    #1;
    d = reg_rdata;
  endtask
endmodule // csfc_host

// ---- tb/tb_charger_safety_fault_control.sv ----
// Self-checking testbench of the charger safety and fault control block.
`timescale 1ns/100ps
`include "csfc_map.svh"
module tb_charger_safety_fault_control;
  import csfc_pkg::*;
  // -------------------------------------------------------------------
  // Signals and instances
  // -------------------------------------------------------------------
  logic           clk_sys = 1'b0;
  logic           reset   = 1'b1;
  csfc_sense_t    sense   = '0;
  csfc_reg_req_t  reg_req;
  logic [7:0]     reg_rdata, rv;
  logic           charge_enable, blocking_switch_on, sleep_active;
  logic           stat_pulse, foldback_active, hold_active;
  logic [2:0]     charge_current_level, input_hold_threshold;
  logic [5:0]     output_voltage_code;
  int             error_cnt = 0;
  int             checks    = 0;

  // Short counts keep every validation and retry wait brief.
  csfc_top #(.VALID_CYC(20), .RETRY_CYC(20)) dut (
    .clk_sys(clk_sys), .reset(reset), .sense(sense), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .charge_enable(charge_enable),
    .blocking_switch_on(blocking_switch_on), .sleep_active(sleep_active),
    .stat_pulse(stat_pulse), .foldback_active(foldback_active),
    .charge_current_level(charge_current_level),
    .output_voltage_code(output_voltage_code),
    .input_hold_threshold(input_hold_threshold),
    .hold_active(hold_active));

  csfc_host host (.clk_sys(clk_sys), .reg_req(reg_req),
                  .reg_rdata(reg_rdata));

  // A 40 ns clock.
  always #20 clk_sys = ~clk_sys;
  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Output selector: 0 charge, 1 switch, 2 sleep, 3 pulse, 4 fold,
  // 5 current level, 6 hold active.
  function automatic logic [7:0] pick(input int k);
    case (k)
      0: pick = {7'h00, charge_enable};
      1: pick = {7'h00, blocking_switch_on};
      2: pick = {7'h00, sleep_active};
      3: pick = {7'h00, stat_pulse};
      4: pick = {7'h00, foldback_active};
      5: pick = {5'h00, charge_current_level};
      default: pick = {7'h00, hold_active};
    endcase
  endfunction

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Masked register read, so undefined neighbours do not matter.
  task automatic chk_rd(input logic [7:0] a, m, e);
    host.rd(a, rv);
    chk8(rv & m, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait for an output; running out ends the run.
  task automatic wait_sig(input int k, input logic [7:0] v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      cyc(1);
      n++;
    end
    checks++;
    if (n >= lim) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, pick(k), v);
      stop_test();
    end
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  // Ceiling lock life cycle and clamping, one step above the limit.
  task automatic t_ceiling();
    host.wr_ceil(8'h35);
    chk_rd(`CSFC_ADDR_CEIL, 8'hFF, 8'h00);
    @(posedge clk_sys) sense.vbat_ok <= 1'b1;
    cyc(3);
    host.wr_ceil(8'h35);
    chk_rd(`CSFC_ADDR_CEIL, 8'hFF, 8'h35);
    host.wr(`CSFC_ADDR_VOUT, 8'hA4);
    chk_rd(`CSFC_ADDR_VOUT, 8'hFF, 8'hA0);
    host.wr_ceil(8'h7F);
    chk_rd(`CSFC_ADDR_CEIL, 8'hFF, 8'h35);
    host.wr(`CSFC_ADDR_VOUT, 8'h80);
    chk_rd(`CSFC_ADDR_VOUT, 8'hFF, 8'h80);
    chk8({2'h0, output_voltage_code}, 8'h20);
    host.wr(`CSFC_ADDR_ICHG, 8'h40);
    chk_rd(`CSFC_ADDR_ICHG, 8'hFF, 8'h30);
    host.wr(`CSFC_ADDR_HOLD, 8'h07);
    chk_rd(`CSFC_ADDR_HOLD, 8'h07, 8'h07);
    chk8({5'h00, input_hold_threshold}, 8'h07);
    chk_rd(8'h10, 8'hFF, 8'h00);
  endtask

  // Validation delay, current ramp up to the code, hold loop flag.
  task automatic t_charge();
    @(posedge clk_sys) begin
      sense.vbus_min     <= 1'b1;
      sense.input_overvoltage_threshold_clr <= 1'b1;
    end
    cyc(15);
    chk8(pick(0), 8'h00);
    wait_sig(0, 8'h01, 10);
    wait_sig(5, 8'h01, 3000);
    // A reached current limit must hold the ramp where it stands.
    @(posedge clk_sys) sense.at_limit <= 1'b1;
    cyc(2600);
    chk8(pick(5), 8'h01);
    @(posedge clk_sys) sense.at_limit <= 1'b0;
    wait_sig(5, 8'h03, 8000);
    cyc(3000);
    chk8(pick(5), 8'h03);
    @(posedge clk_sys) sense.vbus_hold <= 1'b1;
    wait_sig(6, 8'h01, 4);
    chk_rd(`CSFC_ADDR_HOLD, 8'hFF, 8'h17);
    @(posedge clk_sys) sense.vbus_hold <= 1'b0;
  endtask

  // Foldback, then shutdown with frozen state and an unchanged resume.
  task automatic t_thermal();
    @(posedge clk_sys) sense.die_fold <= 1'b1;
    wait_sig(4, 8'h01, 4);
    wait_sig(5, 8'h00, 4);
    @(posedge clk_sys) sense.die_fold <= 1'b0;
    wait_sig(5, 8'h03, 8000);
    @(posedge clk_sys) sense.die_shut <= 1'b1;
    wait_sig(3, 8'h01, 4);
    chk8(pick(0), 8'h00);
    chk_rd(`CSFC_ADDR_FAULT, 8'h07, 8'h05);
    cyc(100);
    @(posedge clk_sys) sense.die_shut <= 1'b0;
    wait_sig(0, 8'h01, 4);
    chk_rd(`CSFC_ADDR_FAULT, 8'h07, 8'h00);
    wait_sig(3, 8'h00, 3300);
  endtask

  // Overvoltage trip, hysteresis release and revalidation.
  task automatic t_ovp();
    @(posedge clk_sys) begin
      sense.input_overvoltage_threshold     <= 1'b1;
      sense.input_overvoltage_threshold_clr <= 1'b0;
    end
    wait_sig(1, 8'h00, 4);
    chk8(pick(0), 8'h00);
    chk8(pick(3), 8'h01);
    chk_rd(`CSFC_ADDR_FAULT, 8'h37, 8'h31);
    @(posedge clk_sys) begin
      sense.input_overvoltage_threshold     <= 1'b0;
      sense.input_overvoltage_threshold_clr <= 1'b1;
    end
    cyc(3);
    chk_rd(`CSFC_ADDR_FAULT, 8'h07, 8'h00);
    chk8(pick(0), 8'h00);
    wait_sig(0, 8'h01, 30);
    chk8(pick(1), 8'h01);
    wait_sig(3, 8'h00, 3300);
  endtask

  // Undervoltage stop, retry interval, then sleep entry.
  task automatic t_under();
    @(posedge clk_sys) sense.vbus_min <= 1'b0;
    wait_sig(0, 8'h00, 4);
    chk8(pick(3), 8'h01);
    chk_rd(`CSFC_ADDR_FAULT, 8'h37, 8'h33);
    @(posedge clk_sys) sense.vbus_min <= 1'b1;
    cyc(30);
    chk8(pick(0), 8'h00);
    wait_sig(0, 8'h01, 60);
    wait_sig(3, 8'h00, 3300);
    @(posedge clk_sys) sense.vbus_sleep <= 1'b1;
    wait_sig(2, 8'h01, 4);
    chk8(pick(0), 8'h00);
    @(posedge clk_sys) sense.vbus_sleep <= 1'b0;
  endtask

  // Battery short and recovery reload and reopen the ceiling.
  task automatic t_relock();
    @(posedge clk_sys) sense.vbat_ok <= 1'b0;
    cyc(3);
    @(posedge clk_sys) sense.vbat_ok <= 1'b1;
    cyc(3);
    chk_rd(`CSFC_ADDR_CEIL, 8'hFF, 8'h00);
    chk_rd(`CSFC_ADDR_ICHG, 8'hFF, 8'h00);
    host.wr_ceil(8'h12);
    chk_rd(`CSFC_ADDR_CEIL, 8'hFF, 8'h12);
  endtask

  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_ceiling();
    t_charge();
    t_thermal();
    t_ovp();
    t_under();
    t_relock();
    stop_test();
  end
endmodule // tb_charger_safety_fault_control
